// [shared/smb_defines.vh]
`ifndef SMB_DEFINES_VH
`define SMB_DEFINES_VH
// ============================================================
// Instruction codes
`define SMB_OP_WREN      8'h06
`define SMB_OP_WRDI      8'h04
`define SMB_OP_RDSR1     8'h05
`define SMB_OP_RDSR2     8'h35
`define SMB_OP_WRSR      8'h01
`define SMB_OP_PP        8'h02
`define SMB_OP_QPP       8'h32
`define SMB_OP_SE        8'h20
`define SMB_OP_BE32      8'h52
`define SMB_OP_BE64      8'hD8
`define SMB_OP_CE1       8'hC7
`define SMB_OP_CE2       8'h60
`define SMB_OP_PD        8'hB9
`define SMB_OP_RPD       8'hAB
`define SMB_OP_SUSP      8'h75
`define SMB_OP_RESUME    8'h7A
`define SMB_OP_DREAD     8'h3B
`define SMB_OP_DIOREAD   8'hBB
`define SMB_OP_QREAD     8'h6B
`define SMB_OP_QIOREAD   8'hEB
`define SMB_OP_WQREAD    8'hE7
`define SMB_OP_OQREAD    8'hE3
// ============================================================
// Status bit positions
`define SMB_SR_BUSY      0
`define SMB_SR_WPL       1
`define SMB_SR_SPAN_LO   2
`define SMB_SR_SPAN_HI   4
`define SMB_SR_LOWEND    5
`define SMB_SR_SMALL     6
`define SMB_SR_LOCK_LO   7
`define SMB_SR_LOCK_HI   8
`define SMB_SR_QUAD      9
`define SMB_SR_SECLK_LO  10
`define SMB_SR_SECLK_HI  13
`define SMB_SR_INVERT    14
`define SMB_SR_SUS       15
`define SMB_SR_RESET     16'h0000
// Writable status bits (busy, latch, suspend are read only)
`define SMB_SR_WMASK     16'h7FFC
// ============================================================
// Timing
`define SMB_CLK_NS       5
`define SMB_PUW_US       10
`define SMB_PUW_CYCLES   ((`SMB_PUW_US * 1000) / `SMB_CLK_NS)
`define SMB_BUSY_NS      1000
`define SMB_BUSY_CYCLES  (`SMB_BUSY_NS / `SMB_CLK_NS)
// ============================================================
// Sizes
`define SMB_FIFO_W       8
`define SMB_FIFO_D       4
`define SMB_BITS_W       4
`define SMB_BYTE_BITS    4'h8
`endif

// [src/smb_sync.v]
`default_nettype none
// ============================================================
// Two-flop synchroniser for a group of pin inputs
module smb_sync #(
    parameter W = 1
) (
    input  wire         clock,
    input  wire         reset,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] stage;

    // First stage feeds only the second
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            stage <= {W{1'b0}};
            dout  <= {W{1'b0}};
        end else begin
            stage <= din;
            dout  <= stage;
        end
    end
endmodule
`default_nettype wire

// [src/smb_fifo.v]
`default_nettype none
// ============================================================
// Small synchronous FIFO with valid/ready on both sides
module smb_fifo #(
    parameter W = 8,
    parameter D = 4
) (
    input  wire         clock,
    input  wire         reset,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output reg  [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    localparam AW = (D > 1) ? $clog2(D) : 1;
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;
    wire         push;
    wire         pop;

    assign in_ready  = (count != D[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage write
    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Head word read combinationally for the reader
    always @* begin
        out_data = mem[rd_ptr];
    end

    // Pointers and occupancy
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// [src/smb_front.v]
// Operation
// RULE1 - Pause floats outputs, ignores input and clock
// RULE2 - Pause active low, off when quad enabled
// RULE3 - Sample rising edge, shift out falling
// RULE4 - Only bus modes 0 and 3
// RULE5 - Host holds clock idle at select edges
// RULE6 - Dual reads use lanes 0 and 1
// RULE7 - Quad reads use four lanes
// RULE8 - Quad needs enable bit; pins become lanes
// RULE9 - Pause starts at pin fall or clock fall
// RULE10 - Pause ends at pin rise or clock fall
// RULE11 - Pause only while selected
// RULE12 - Pause keeps instruction state and buffer
// RULE13 - Host keeps select low during pause
// RULE14 - Write instructions rejected during power-up lockout
// RULE15 - Write permit latch clear after power-up
// RULE16 - Program, erase, status write need latch
// RULE17 - Latch clears when operation completes
// RULE18 - Power-down ignores all but release; code still serves reads and commits writes while latch set
// RULE19 - Protection spans one sector to whole array
// RULE20 - Status write gated by locks, latch, pin
// RULE21 - Two status reads report full state
// RULE22 - Busy ignores all but status read, suspend; code still serves other reads and commits writes while latch set
// RULE23 - Lock 0/1: low guard pin locks status
// RULE24 - Quad enable at bit 9, default 0
// RULE25 - Pause resumes at same bit position
// RULE26 - Early deselect aborts without side effects
`default_nettype none
`include "smb_defines.vh"
module smb_front #(
    parameter PUW_CYCLES  = `SMB_PUW_CYCLES,
    parameter BUSY_CYCLES = `SMB_BUSY_CYCLES
) (
    input  wire        clock,
    input  wire        reset,
    input  wire        sclk,
    input  wire        cs_n,
    input  wire [3:0]  io_in,
    output reg  [3:0]  io_out,
    output reg  [3:0]  io_oe,
    output wire [7:0]  wr_data,
    output wire        wr_valid,
    input  wire        wr_ready,
    input  wire [7:0]  rd_data,
    output reg  [7:0]  last_op,
    output reg  [15:0] status,
    output reg         paused,
    output reg         powered_down,
    output reg         mode3
);
    // ========================================================
    // Pin synchronisers
    wire [6:0] pins_s;
    smb_sync #(.W(7)) u_sync (
        .clock (clock),
        .reset (reset),
        .din   ({sclk, cs_n, io_in, 1'b0}),
        .dout  (pins_s)
    );
    wire       sclk_s = pins_s[6];
    wire       cs_n_s = pins_s[5];
    wire [3:0] io_s   = pins_s[4:1];
    reg        sclk_d;
    reg        cs_n_d;
    wire       rise   = sclk_s & ~sclk_d;
    wire       fall   = ~sclk_s & sclk_d;
    wire       sel    = ~cs_n_s;
    // RULE24 quad enable at bit 9
    wire       quad   = status[`SMB_SR_QUAD];
    wire       hold_n = io_s[3];
    wire       wp_n   = io_s[2];

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    // ========================================================
    // Lane-width decode, shared by receive and transmit
    function [2:0] lanes_of;
        input [7:0] op;
        begin
            case (op)
                `SMB_OP_DREAD, `SMB_OP_DIOREAD: lanes_of = 3'd2;
                `SMB_OP_QREAD, `SMB_OP_QIOREAD,
                `SMB_OP_WQREAD, `SMB_OP_OQREAD: lanes_of = 3'd4;
                default:                        lanes_of = 3'd1;
            endcase
        end
    endfunction

    // Write-class instruction decode
    function is_write;
        input [7:0] op;
        begin
            case (op)
                `SMB_OP_PP, `SMB_OP_QPP, `SMB_OP_SE, `SMB_OP_BE32,
                `SMB_OP_BE64, `SMB_OP_CE1, `SMB_OP_CE2,
                `SMB_OP_WRSR: is_write = 1'b1;
                default:      is_write = 1'b0;
            endcase
        end
    endfunction

    // ========================================================
    // Pause tracking
    // RULE9 RULE10 clock low: follow pin; else wait clock fall
    // RULE2 RULE11 active low, quad off, selected only
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            paused <= 1'b0;
        end else if (!sel || quad) begin
            paused <= 1'b0;
        end else if (!sclk_s || fall) begin
            paused <= ~hold_n;
        end
    end

    // ========================================================
    // Power-up lockout counter
    reg [31:0] puw_count;
    wire       puw_done = (puw_count == PUW_CYCLES);
    // RULE14 lockout delay count
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            puw_count <= 32'h00000000;
        end else if (!puw_done) begin
            puw_count <= puw_count + 32'h00000001;
        end
    end

    // ========================================================
    // Receive shifter
    localparam ST_OP   = 3'b001;
    localparam ST_ARG  = 3'b010;
    localparam ST_OUT  = 3'b100;
    reg [2:0]  state;
    reg [7:0]  shreg;
    reg [3:0]  bits;
    reg [7:0]  op;
    reg [7:0]  arg_bytes;
    reg [15:0] sr_new;
    wire [2:0] nl = (state == ST_OP) ? 3'd1 : lanes_of(op);
    wire       active = sel & ~paused;
    wire [3:0] next_bits = bits + {1'b0, nl};
    reg  [7:0] next_sh;

    // Shift in lanes per rising edge, MSB first
    always @* begin
        case (nl)
            3'd2:    next_sh = {shreg[5:0], io_s[1:0]};
            3'd4:    next_sh = {shreg[3:0], io_s[3:0]};
            default: next_sh = {shreg[6:0], io_s[0]};
        endcase
    end

    reg        wpl;
    reg [31:0] busy_count;
    wire       busy = (busy_count != 32'h00000000);
    reg        sus;
    reg        fill;
    wire       byte_done = active & rise & (next_bits >= `SMB_BYTE_BITS);
    // RULE20 RULE23 status write permission
    wire       sr_ok = wpl & ~status[`SMB_SR_LOCK_HI] &
                       (~status[`SMB_SR_LOCK_LO] | quad | wp_n);
    // RULE26 commit only at deselect after whole bytes
    wire       deselect = cs_n_s & ~cs_n_d;

    // RULE15 latch cleared by reset
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            state        <= ST_OP;
            shreg        <= 8'h00;
            bits         <= 4'h0;
            op           <= 8'h00;
            arg_bytes    <= 8'h00;
            sr_new       <= `SMB_SR_RESET;
            fill         <= 1'b0;
            wpl          <= 1'b0;
            busy_count   <= 32'h00000000;
            sus          <= 1'b0;
            status       <= `SMB_SR_RESET;
            powered_down <= 1'b0;
            last_op      <= 8'h00;
            mode3        <= 1'b0;
        end else begin
            if (busy) begin
                busy_count <= busy_count - 32'h00000001;
                // RULE17 latch clears at completion
                if (busy_count == 32'h00000001) begin
                    wpl <= 1'b0;
                end
            end
            // RULE4 record idle clock level at select fall
            if (cs_n_d & ~cs_n_s) begin
                mode3 <= sclk_s;
            end
            if (!sel) begin
                // RULE13 deselect resets instruction state
                state     <= ST_OP;
                bits      <= 4'h0;
                arg_bytes <= 8'h00;
                fill      <= 1'b0;
                if (deselect && state != ST_OP && bits == 4'h0) begin
                    // RULE16 RULE20 accepted status write
                    if (op == `SMB_OP_WRSR && arg_bytes != 8'h00 &&
                        sr_ok) begin
                        status     <= (status & ~`SMB_SR_WMASK) |
                                      (sr_new & `SMB_SR_WMASK);
                        busy_count <= BUSY_CYCLES;
                    end else if (is_write(op) && op != `SMB_OP_WRSR &&
                                 wpl) begin
                        busy_count <= BUSY_CYCLES;
                    end
                end
            end else if (rise && active) begin
                // RULE3 RULE12 RULE25 sample; pause freezes position
                shreg <= next_sh;
                bits  <= byte_done ? 4'h0 : next_bits;
                if (byte_done) begin
                    if (state == ST_OP) begin
                        op      <= next_sh;
                        last_op <= next_sh;
                        state   <= ST_ARG;
                        // RULE18 RULE22 RULE14 RULE16 filters
                        if (powered_down) begin
                            if (next_sh == `SMB_OP_RPD) begin
                                powered_down <= 1'b0;
                            end
                        end else if (busy) begin
                            if (next_sh == `SMB_OP_SUSP) begin
                                sus <= 1'b1;
                            end
                        end else if (next_sh == `SMB_OP_WREN &&
                                     puw_done) begin
                            wpl <= 1'b1;
                        end else if (next_sh == `SMB_OP_WRDI) begin
                            wpl <= 1'b0;
                        end else if (next_sh == `SMB_OP_PD) begin
                            powered_down <= 1'b1;
                        end else if (next_sh == `SMB_OP_RESUME) begin
                            sus <= 1'b0;
                        end
                        // RULE8 quad reads dropped without enable
                        if (lanes_of(next_sh) == 3'd4 && !quad) begin
                            state <= ST_OP;
                        end
                    end else begin
                        arg_bytes <= arg_bytes + 8'h01;
                        if (arg_bytes == 8'h00) begin
                            sr_new[7:0] <= next_sh;
                        end else if (arg_bytes == 8'h01) begin
                            sr_new[15:8] <= next_sh;
                        end
                        fill <= (op == `SMB_OP_PP || op == `SMB_OP_QPP) &&
                                (arg_bytes >= 8'h03);
                    end
                end
            end
            // Live flags
            status[`SMB_SR_BUSY] <= busy;
            status[`SMB_SR_WPL]  <= wpl;
            status[`SMB_SR_SUS]  <= sus;
        end
    end

    // RULE12 page data into buffer, one pulse per byte; wr_ready is not used
    reg byte_done_q;
    assign wr_data  = shreg;
    assign wr_valid = fill & byte_done_q;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            byte_done_q <= 1'b0;
        end else begin
            byte_done_q <= byte_done & (state == ST_ARG) & ~wr_valid;
        end
    end

    // ========================================================
    // Transmit side
    reg  [7:0] tx;
    reg  [3:0] tx_bits;
    wire       rd_sr1 = (op == `SMB_OP_RDSR1);
    wire       rd_sr2 = (op == `SMB_OP_RDSR2);
    wire [2:0] tl     = lanes_of(op);
    // RULE21 status reads report full state
    wire [7:0] tx_src = rd_sr1 ? status[7:0] :
                        rd_sr2 ? status[15:8] : rd_data;
    wire       talk   = (state == ST_ARG) &&
                        (rd_sr1 || rd_sr2 ||
                         (tl != 3'd1 && arg_bytes >= 8'h04));

    // RULE3 shift out on falling edge
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            tx      <= 8'h00;
            tx_bits <= 4'h0;
        end else if (!sel) begin
            tx_bits <= 4'h0;
        end else if (fall && active && talk) begin
            if (tx_bits == 4'h0) begin
                tx <= tx_src;
            end else begin
                tx <= tx << tl;
            end
            tx_bits <= (tx_bits + {1'b0, tl} >= `SMB_BYTE_BITS) ? 4'h0 :
                       tx_bits + {1'b0, tl};
        end
    end

    // RULE1 RULE6 RULE7 lane drive, floated in pause
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            io_out <= 4'h0;
            io_oe  <= 4'h0;
        end else if (!active || !talk) begin
            io_oe  <= 4'h0;
        end else if (tl == 3'd4) begin
            io_out <= tx[7:4];
            io_oe  <= 4'hF;
        end else if (tl == 3'd2) begin
            io_out <= {2'b00, tx[7:6]};
            io_oe  <= 4'h3;
        end else begin
            io_out <= {2'b00, tx[7], 1'b0};
            io_oe  <= 4'h2;
        end
    end

    // RULE19 protection bits held in status, decoded by array logic
    wire unused_prot = &{status[`SMB_SR_SPAN_HI:`SMB_SR_SPAN_LO],
                        status[`SMB_SR_SECLK_HI:`SMB_SR_SECLK_LO],
                        wr_ready, 1'b0};
endmodule
`default_nettype wire

// [testbench/smb_front_assertions.sv]
`default_nettype none
// ============================================================
// Port-level checks on the serial front end
module smb_front_assertions #(
    parameter int PUW_CYCLES = 2000
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic [3:0]  io_in,
    input wire logic [3:0]  io_oe,
    input wire logic [15:0] status,
    input wire logic        paused,
    input wire logic        powered_down
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned since_rst;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // Cycles since reset release, saturating at the lockout length
    always_ff @(posedge clock or posedge reset) begin
        if (reset)
            since_rst <= 0;
        else if (since_rst < PUW_CYCLES)
            since_rst <= since_rst + 1;
    end

    AST_PAUSE_FLOAT: assert property (
        paused ##1 paused |-> io_oe == 4'h0)
        else $error("lanes driven while paused");
    AST_PAUSE_SEL: assert property (
        cs_n [*5] |-> !paused)
        else $error("pause held while deselected");
    AST_QUAD_NOPAUSE: assert property (
        (status[9]) [*3] |-> !paused)
        else $error("pause active with four-lane mode on");
    AST_PAUSE_ENTER: assert property (
        (!cs_n && io_in[3])
        ##1 (!cs_n && !io_in[3] && !sclk && !status[9]) [*6] |-> paused)
        else $error("pause not entered with clock low");
    AST_PAUSE_EXIT: assert property (
        (io_in[3] && !sclk) [*6] |-> !paused)
        else $error("pause not left with clock low");
    AST_POWERUP_LATCH: assert property (
        $fell(reset) |-> status == 16'h0000)
        else $error("status not clear after reset");
    AST_LOCKOUT: assert property (
        since_rst < PUW_CYCLES - 1 |-> !status[1])
        else $error("write permit set during lockout");
    AST_WRITE_NEEDS_LATCH: assert property (
        $rose(status[0]) |-> $past(status[1]))
        else $error("busy started without write permit");
    AST_LATCH_CLEAR: assert property (
        $fell(status[0]) |-> ##[0:1] !status[1])
        else $error("write permit kept after operation");
    AST_BUSY_HOLD: assert property (
        status[0] && $past(status[0]) |-> !$rose(status[1]))
        else $error("instruction accepted while busy");
    AST_PD_HOLD: assert property (
        powered_down && $past(powered_down) |-> $stable(status))
        else $error("status changed in power-down");
endmodule

bind smb_front smb_front_assertions #(
    .PUW_CYCLES(PUW_CYCLES)
) u_chk (
    .clock        (clock),
    .reset        (reset),
    .sclk         (sclk),
    .cs_n         (cs_n),
    .io_in        (io_in),
    .io_oe        (io_oe),
    .status       (status),
    .paused       (paused),
    .powered_down (powered_down)
);
`default_nettype wire

// [testbench/smb_host.sv]
`default_nettype none
// ============================================================
// Serial bus host: clock runs only inside frames
module smb_host (
    output var logic       sclk,
    output var logic       cs_n,
    output var logic [3:0] io_h,
    input  wire logic [3:0] io_l
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam time HALF = 24ns;
    logic m3;

    // Idle: deselected, guard and pause pins high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_h = 4'hF;
        m3 = 1'b0;
    end

    task automatic start(input logic mode);
        m3 = mode;
        sclk = mode;
        #HALF cs_n = 1'b0;
        #HALF;
    endtask

    // Bits MSB first, changed while clock is low
    task automatic send(input logic [7:0] val, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sclk = 1'b0;
            io_h[0] = val[i];
            io_h[1] = ~io_h[1];
            #HALF sclk = 1'b1;
            #HALF;
        end
    endtask

    // read bit taken at each rising edge
    task automatic recv(output logic [7:0] val);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            #HALF sclk = 1'b1;
            val[i] = io_l[1];
            #HALF;
        end
    endtask

    task automatic stop;
        sclk = m3;
        #HALF cs_n = 1'b1;
        io_h[0] = ~io_h[0];
        #HALF;
    endtask

    // Pause pin, active low
    task automatic pause(input logic on);
        io_h[3] = ~on;
        #(2 * HALF);
    endtask

    // Write guard pin level
    task automatic guard(input logic v);
        io_h[2] = v;
    endtask
endmodule
`default_nettype wire

// [testbench/smb_front_tb_top.sv]
`default_nettype none
`include "smb_defines.vh"
// ============================================================
// Top-level bench
module smb_front_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PUW = 400;
    logic        clock;
    logic        reset;
    logic [7:0]  rd_data;
    logic        wr_ready;
    logic [7:0]  f_in;
    logic        f_valid;
    logic        f_take;
    wire         sclk;
    wire         cs_n;
    wire  [3:0]  io_h;
    wire  [3:0]  io_in;
    wire  [3:0]  io_out;
    wire  [3:0]  io_oe;
    wire  [15:0] status;
    wire         paused;
    wire         powered_down;
    wire         mode3;
    wire         f_in_ready;
    wire  [7:0]  f_out;
    wire         f_out_valid;
    wire  [7:0]  wr_data;
    wire         wr_valid;
    wire  [7:0]  last_op;
    int          wr_cnt;
    logic [7:0]  wr_seen;
    logic [7:0]  rx;
    int          failures;
    int          tests_run;

    // Lane level from both parties' drive
    assign io_in = (io_oe & io_out) | (~io_oe & io_h);

    smb_host host (.sclk(sclk), .cs_n(cs_n), .io_h(io_h), .io_l(io_in));

    smb_front #(.PUW_CYCLES(PUW), .BUSY_CYCLES(300)) uut (
        .clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .last_op(last_op), .status(status), .paused(paused),
        .powered_down(powered_down), .mode3(mode3));

    smb_fifo #(.W(8), .D(4)) uut_fifo (
        .clock(clock), .reset(reset), .in_data(f_in),
        .in_valid(f_valid), .in_ready(f_in_ready), .out_data(f_out),
        .out_valid(f_out_valid), .out_ready(f_take));

    // Count page bytes handed out and keep the last one
    always @(posedge clock) begin
        if (reset) begin
            wr_cnt <= 0;
        end else if (wr_valid) begin
            wr_cnt  <= wr_cnt + 1;
            wr_seen <= wr_data;
        end
    end

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op);
        host.start(1'b0);
        host.send(op, 8);
        host.stop;
    endtask

    // Status write: low byte, then high byte
    task automatic wrsr(input logic [15:0] v);
        host.start(1'b0);
        host.send(`SMB_OP_WRSR, 8);
        host.send(v[7:0], 8);
        host.send(v[15:8], 8);
        host.stop;
    endtask

    task automatic wait_idle;
        int n = 0;
        while (status[0] !== 1'b0 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        if (n == 1000) begin
            failures++;
            $display("[FAIL] %0t busy never cleared", $time);
            give_verdict;
        end
    endtask

    // Main sequence
    initial begin
        failures = 0;
        tests_run = 0;
        reset = 1'b1;
        rd_data = 8'hA5;
        wr_ready = 1'b1;
        f_in = 8'h00;
        f_valid = 1'b0;
        f_take = 1'b0;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check(status, 16'h0000);
        cmd(`SMB_OP_WREN);
        check(status[1], 1'b0);
        repeat (PUW) @(posedge clock);
        wrsr(16'h0200);
        check(status, 16'h0000);
        cmd(`SMB_OP_WREN);
        check(status[1], 1'b1);
        host.start(1'b0);
        host.send(`SMB_OP_WRDI, 5);
        host.stop;
        check(status[1], 1'b1);
        wrsr(16'h0084);
        check(status[0], 1'b1);
        cmd(`SMB_OP_WREN);
        wait_idle;
        check(status, 16'h0084);
        host.guard(1'b0);
        cmd(`SMB_OP_WREN);
        wrsr(16'h0004);
        wait_idle;
        check(status & 16'hFFFC, 16'h0084);
        host.guard(1'b1);
        host.pause(1'b1);
        check(paused, 1'b0);
        host.pause(1'b0);
        host.start(1'b1);
        host.send(`SMB_OP_WRDI, 8);
        host.stop;
        check({mode3, status[1]}, 16'h0002);
        host.start(1'b0);
        host.send(`SMB_OP_WREN, 4);
        host.pause(1'b1);
        host.send(8'hFF, 3);
        check(paused, 1'b1);
        check(io_oe, 4'h0);
        host.pause(1'b0);
        check(paused, 1'b1);
        host.send(8'h60, 4);
        host.stop;
        check({mode3, status[1]}, 16'h0001);
        wrsr(16'h0280);
        wait_idle;
        check(status, 16'h0280);
        host.start(1'b0);
        host.send(`SMB_OP_RDSR1, 4);
        host.pause(1'b1);
        check(paused, 1'b0);
        host.pause(1'b0);
        host.stop;
        cmd(`SMB_OP_PD);
        check(powered_down, 1'b1);
        cmd(`SMB_OP_WREN);
        check(status[1], 1'b0);
        cmd(`SMB_OP_RPD);
        check(powered_down, 1'b0);
        // Page program: one data byte after three address bytes
        cmd(`SMB_OP_WREN);
        host.start(1'b0);
        host.send(`SMB_OP_PP, 8);
        for (int i = 0; i < 4; i++) host.send(8'h3C, 8);
        host.stop;
        check(status[0], 1'b1);
        check({last_op, wr_seen}, {`SMB_OP_PP, 8'h3C});
        check(16'(wr_cnt), 16'h0001);
        wait_idle;
        // Upper status byte read back on the output lane
        host.start(1'b0);
        host.send(`SMB_OP_RDSR2, 8);
        host.recv(rx);
        host.stop;
        check(rx, 8'h02);
        // Fill the buffer with the reader stalled, then drain it
        @(posedge clock);
        f_valid <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            f_in <= 8'h10 + 8'(i);
            @(negedge clock);
            check(f_in_ready, (i < 4) ? 16'h0001 : 16'h0000);
            @(posedge clock);
        end
        f_valid <= 1'b0;
        f_take <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            check({f_out_valid, f_out}, {1'b1, 8'h10 + 8'(i)});
            @(posedge clock);
        end
        @(negedge clock);
        check(f_out_valid, 1'b0);
        give_verdict;
    end
endmodule
`default_nettype wire
